// ### verilog/acr_control_reg.sv
// Control register of the data acquisition converter, loaded in parallel or serially
//
// Behaviour
// - six-bit control register with channel, start, standby, format
// - parallel or serial write loads all six bits
// - register clears to zero at reset
// - short frame discards write, keeps old value
// - short frame with start bit set converts
// - bits captured on first six falling edges
// - later serial edges ignored while frame low
// - interface select high parallel, low serial
// - start bit set converts after settling pulse
`timescale 1ns/1ps
module acr_control_reg #(
	parameter int SETTLE_COUNT = acr_pkg::SETTLE_CYCLES
) (
	input  wire logic                            clk,
	input  wire logic                            nrst,
	input  wire logic                            parallelSelect,
	input  wire logic                            chipSelect_n,
	input  wire logic                            writeStrobe_n,
	input  wire logic [acr_pkg::CTRL_WIDTH-1:0] parallelData,
	input  wire logic                            serialClock,
	input  wire logic                            transmit_frame_sync_n,
	input  wire logic                            serialDataIn,
	output logic      [2:0]                      channelSel,
	output logic                                 soft_convert_bit,
	output logic                                 soft_standby_bit,
	output logic                                 formatBit,
	output logic                                 convertStart
);
	import acr_pkg::*;

	// Pin synchronisers: first stage is read only by the second, and no gate sits in front of them
	logic [5:0]            sync1_reg;
	logic [5:0]            sync2_reg;
	logic [CTRL_WIDTH-1:0] dataSync1_reg;
	logic [CTRL_WIDTH-1:0] dataSync2_reg;
	logic                  sclkPrev_reg;
	logic                  framePrev_reg;
	logic                  wrPrev_reg;

	// Control pins; reset to their idle levels so that no false edge follows reset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sync1_reg <= 6'h3F;
			sync2_reg <= 6'h3F;
		end else begin
			sync1_reg <= {parallelSelect, writeStrobe_n, chipSelect_n, serialClock, transmit_frame_sync_n,
				serialDataIn};
			sync2_reg <= sync1_reg;
		end
	end

	// Parallel data pins, delayed as much as the strobe so that data and strobe stay aligned
	always_ff @(posedge clk) begin
		if (!nrst) begin
			dataSync1_reg <= CTRL_RESET;
			dataSync2_reg <= CTRL_RESET;
		end else begin
			dataSync1_reg <= parallelData;
			dataSync2_reg <= dataSync1_reg;
		end
	end

	// Edge tests, shared by the serial clock, the frame and the write strobe
	function automatic logic fellEdge(input logic prevLevel, input logic nowLevel);
		return prevLevel && !nowLevel;
	endfunction

	function automatic logic roseEdge(input logic prevLevel, input logic nowLevel);
		return !prevLevel && nowLevel;
	endfunction

	wire modeParallel = sync2_reg[5];
	wire wrLevel_n    = sync2_reg[4] | sync2_reg[3]; // Strobe and select combined only after both are synchronised
	wire sclkLevel    = sync2_reg[2];
	wire frameLevel_n = sync2_reg[1];
	wire dinLevel     = sync2_reg[0];

	// Edge history of the synchronised levels
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sclkPrev_reg  <= 1'b1;
			framePrev_reg <= 1'b1;
			wrPrev_reg    <= 1'b1;
		end else begin
			sclkPrev_reg  <= sclkLevel;
			framePrev_reg <= frameLevel_n;
			wrPrev_reg    <= wrLevel_n;
		end
	end

	wire sclkFall  = fellEdge(sclkPrev_reg, sclkLevel);
	wire frameFall = fellEdge(framePrev_reg, frameLevel_n);
	wire frameRise = roseEdge(framePrev_reg, frameLevel_n);
	wire wrRise    = roseEdge(wrPrev_reg, wrLevel_n);

	// Parallel data is followed while the synchronised strobe is low, so the value before the rise is kept
	// Limitation: the host must hold the data for the whole strobe and a few clocks after it
	logic [CTRL_WIDTH-1:0] parLatch_reg;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			parLatch_reg <= CTRL_RESET;
		end else if (!wrLevel_n) begin
			parLatch_reg <= dataSync2_reg;
		end
	end

	// Serial frame state machine
	acr_ser_state_type     state_reg;
	acr_ser_state_type     state_next;
	logic [2:0]            bitCount_reg;
	logic [2:0]            bitCount_next;
	logic [CTRL_WIDTH-1:0] shift_reg;
	logic [CTRL_WIDTH-1:0] shift_next;
	logic                  serLoad;
	logic                  serAbort;

	always_comb begin
		state_next    = state_reg;
		bitCount_next = bitCount_reg;
		shift_next    = shift_reg;
		serLoad       = 1'b0;
		serAbort      = 1'b0;
		case (state_reg)
			SER_IDLE: begin
				if (!modeParallel && frameFall) begin
					state_next    = SER_SHIFT;
					bitCount_next = 3'h0;
				end
			end
			SER_SHIFT: begin
				if (modeParallel) begin
					state_next = SER_IDLE;
				end else if (frameRise) begin
					state_next = SER_IDLE;
					serAbort   = 1'b1;
				end else if (sclkFall) begin
					shift_next    = {shift_reg[CTRL_WIDTH-2:0], dinLevel};
					bitCount_next = bitCount_reg + 3'h1;
					if (bitCount_reg + 3'h1 == SERIAL_BITS) begin
						state_next = SER_DONE;
						serLoad    = 1'b1;
					end
				end
			end
			SER_DONE: begin
				if (frameRise) begin
					state_next = SER_IDLE;
				end
			end
			default: begin
				state_next = SER_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_reg    <= SER_IDLE;
			bitCount_reg <= 3'h0;
			shift_reg    <= CTRL_RESET;
		end else begin
			state_reg    <= state_next;
			bitCount_reg <= bitCount_next;
			shift_reg    <= shift_next;
		end
	end

	// Register load selection by interface mode
	// Only one path can fire in a given mode, so the priority below never decides anything
	wire                  parLoad   = modeParallel && wrRise;
	wire [CTRL_WIDTH-1:0] serValue  = {shift_reg[CTRL_WIDTH-2:0], dinLevel};
	logic [CTRL_WIDTH-1:0] ctrl_reg;
	wire [CTRL_WIDTH-1:0] ctrl_next = parLoad ? parLatch_reg : (serLoad ? serValue : ctrl_reg);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrl_reg <= CTRL_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// Settling pulse starts on any completed write, or an abort with start already set
	wire settleStart = parLoad || serLoad || (serAbort && ctrl_reg[SOFT_CONV_POS]);
	logic settleDone;
	acr_settle_timer #(
		.CYCLES(SETTLE_COUNT)
	) u_settle (
		.clk    (clk),
		.nrst   (nrst),
		.start  (settleStart),
		.expired(settleDone)
	);

	// Register outputs from flip-flops, loaded in the same cycle as the control register
	always_ff @(posedge clk) begin
		if (!nrst) begin
			channelSel       <= 3'h0;
			soft_convert_bit <= 1'b0;
			soft_standby_bit <= 1'b0;
			formatBit        <= 1'b0;
		end else begin
			channelSel       <= ctrl_next[CHAN_BIT2_POS:CHAN_BIT0_POS];
			soft_convert_bit <= ctrl_next[SOFT_CONV_POS];
			soft_standby_bit <= ctrl_next[SOFT_STBY_POS];
			formatBit        <= ctrl_next[FORMAT_POS];
		end
	end

	// Conversion pulse only if the start bit still holds when the settling pulse runs out
	always_ff @(posedge clk) begin
		if (!nrst) begin
			convertStart <= 1'b0;
		end else begin
			convertStart <= settleDone && ctrl_reg[SOFT_CONV_POS];
		end
	end
endmodule

// ### verilog/acr_pkg.sv
// Package with constants for the ADC control register write block
package acr_pkg;
	localparam int CTRL_WIDTH        = 6;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	// Field positions, shifted in from the top bit down
	localparam int CHAN_BIT2_POS     = 5;
	localparam int CHAN_BIT1_POS     = 4;
	localparam int CHAN_BIT0_POS     = 3;
	localparam int SOFT_CONV_POS     = 2;
	localparam int SOFT_STBY_POS     = 1;
	localparam int FORMAT_POS        = 0;
	localparam logic [2:0] SERIAL_BITS = 3'h6;
	// Settling pulse after a write, in ns, and derived cycles at 125 MHz
	localparam int SETTLE_NS         = 400;
	localparam int CLK_PERIOD_NS     = 8;
	localparam int SETTLE_CYCLES     = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		SER_IDLE  = 2'h0,
		SER_SHIFT = 2'h1,
		SER_DONE  = 2'h3
	} acr_ser_state_type;
endpackage

// ### verilog/acr_settle_timer.sv
// Settling pulse timer whose expiry fires a conversion start when the start bit is set
`timescale 1ns/1ps
module acr_settle_timer #(
	parameter int CYCLES = 50
) (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic start,
	output logic      expired
);
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic        expired_next;

	// Restart on every new write so the last write decides the hold moment
	assign count_next   = start ? 16'(CYCLES) : (count_reg != 16'h0000 ? count_reg - 16'h0001 : 16'h0000);
	assign expired_next = !start && (count_reg == 16'h0001);

	// Down counter and one-cycle expiry pulse
	always_ff @(posedge clk) begin
		if (!nrst) begin
			count_reg <= 16'h0000;
			expired   <= 1'b0;
		end else begin
			count_reg <= count_next;
			expired   <= expired_next;
		end
	end
endmodule

// ### testbench/acr_checker.sv
// Concurrent checks on the control register write block
`timescale 1ns/1ps
module acr_checker #(
	parameter int SETTLE_COUNT = 4
) (
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic       parallelSelect,
	input wire logic       chipSelect_n,
	input wire logic       writeStrobe_n,
	input wire logic       serialClock,
	input wire logic       serialDataIn,
	input wire logic       transmit_frame_sync_n,
	input wire logic       soft_convert_bit,
	input wire logic       soft_standby_bit,
	input wire logic       formatBit,
	input wire logic       convertStart,
	input wire logic [5:0] parallelData,
	input wire logic [2:0] channelSel
);
	localparam int CONV_MAX = SETTLE_COUNT + 10;
	wire  [5:0] regBits = {channelSel, soft_convert_bit, soft_standby_bit, formatBit};
	logic [2:0] nFall;
	logic [4:0] shBits;
	logic [5:0] parWord;
	logic [5:0] serWord;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Falls per frame, saturating so that a long frame never wraps back into range; words kept for the load checks
	always_ff @(posedge clk) begin
		if (transmit_frame_sync_n) nFall <= 3'h0;
		else if ($fell(serialClock) && nFall != 3'h7) nFall <= nFall + 3'h1;
		if ($fell(serialClock) && nFall < 3'h6) shBits <= {shBits[3:0], serialDataIn};
		if ($rose(writeStrobe_n)) parWord <= parallelData;
		if ($fell(serialClock) && nFall == 3'h5) serWord <= {shBits, serialDataIn};
	end
	sequence shortFrame; $rose(transmit_frame_sync_n) && nFall < 3'h6 && !parallelSelect; endsequence
	property parLoad;
		parallelSelect && !chipSelect_n && $rose(writeStrobe_n) |-> ##[1:8] regBits == parWord;
	endproperty
	property serLoad;
		!parallelSelect && !transmit_frame_sync_n && $fell(serialClock) && nFall == 3'h5
			|-> ##[1:8] regBits == serWord;
	endproperty
	// Register contents, then the conversion pulse
	a_reset_clears: assert property (disable iff (1'b0) !nrst |=> regBits == 6'h00) else $error("bad reset");
	a_par_load: assert property (parLoad) else $error("parallel write lost");
	a_ser_load: assert property (serLoad) else $error("serial write lost");
	a_abort_keeps: assert property (shortFrame |-> ##1 $stable(regBits) [*6]) else $error("short frame loaded");
	a_abort_converts: assert property (shortFrame ##0 soft_convert_bit |-> ##[1:CONV_MAX] convertStart)
		else $error("no conversion after short frame");
	a_soft_converts: assert property ($rose(soft_convert_bit) |-> ##[1:CONV_MAX] convertStart)
		else $error("no conversion after write");
	a_conv_pulse: assert property (convertStart |=> !convertStart) else $error("pulse too long");
	a_conv_needs_bit: assert property (convertStart |-> soft_convert_bit) else $error("stray conversion");
	c_par: cover property ($rose(writeStrobe_n) && parallelSelect);
	c_abort: cover property (shortFrame);
	c_ser: cover property (!parallelSelect && $fell(serialClock) && nFall == 3'h5);
	c_conv: cover property (convertStart);
endmodule
bind acr_control_reg acr_checker #(
	.SETTLE_COUNT(SETTLE_COUNT)
) chk (
	.clk                  (clk),
	.nrst                 (nrst),
	.parallelSelect       (parallelSelect),
	.chipSelect_n         (chipSelect_n),
	.writeStrobe_n        (writeStrobe_n),
	.serialClock          (serialClock),
	.serialDataIn         (serialDataIn),
	.transmit_frame_sync_n(transmit_frame_sync_n),
	.soft_convert_bit     (soft_convert_bit),
	.soft_standby_bit     (soft_standby_bit),
	.formatBit            (formatBit),
	.convertStart         (convertStart),
	.parallelData         (parallelData),
	.channelSel           (channelSel)
);

// ### testbench/acr_host_model.sv
// Host model that writes the control register over parallel or serial pins
`timescale 1ns/1ps
module acr_host_model (
	output logic       chipSelect_n,
	output logic       writeStrobe_n,
	output logic       serialClock,
	output logic       transmit_frame_sync_n,
	output logic       serialDataIn,
	output logic [5:0] parallelData,
	input  wire logic  clk
);
	initial {chipSelect_n, writeStrobe_n, serialClock, transmit_frame_sync_n, serialDataIn, parallelData} = 11'h7C0;
	// Data held past the strobe rise, then inverted so a late sample cannot pass
	task automatic parWrite(input logic [5:0] d);
		repeat (2) @(negedge clk);
		{chipSelect_n, writeStrobe_n, parallelData} = {2'h0, d};
		repeat (3) @(negedge clk);
		writeStrobe_n = 1'b1;
		repeat (4) @(negedge clk);
		{chipSelect_n, parallelData} = {1'b1, ~d};
		repeat (20) @(negedge clk);
	endtask
	// Top bit first; fewer than six clocks aborts, more sends extras to be ignored
	task automatic serWrite(input logic [7:0] d, input int n);
		repeat (2) @(negedge clk);
		transmit_frame_sync_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			serialDataIn = d[7 - i];
			repeat (2) @(negedge clk);
			serialClock = 1'b0;
			repeat (5) @(negedge clk);
			serialClock = 1'b1;
			repeat (3) @(negedge clk);
		end
		{transmit_frame_sync_n, serialDataIn} = {1'b1, ~serialDataIn};
		repeat (20) @(negedge clk);
	endtask
endmodule

// ### testbench/testbench.sv
// Testbench for the control register write block
`timescale 1ns/1ps
module testbench;
	logic       clk = 1'b0, nrst = 1'b0, parallelSelect = 1'b1;
	logic       chipSelect_n, writeStrobe_n, serialClock, transmit_frame_sync_n, serialDataIn;
	logic       soft_convert_bit, soft_standby_bit, formatBit, convertStart;
	logic [5:0] parallelData;
	logic [2:0] channelSel;
	int         nErrors = 0, nCompared = 0, nConv = 0, cyc = 0;
	// Steps: data, serial clocks (0 = parallel), expected register and pulse count
	logic [7:0] dat [7] = '{8'h2D, 8'h12, 8'hC6, 8'h10, 8'hFF, 8'h28, 8'h00};
	int         nb [7] = '{0, 0, 8, 6, 3, 6, 2};
	logic [7:0] expv [7] = '{8'hB5, 8'hB5, 8'hC5, 8'h12, 8'h13, 8'h2B, 8'h2B};
	wire  [5:0] regBits = {channelSel, soft_convert_bit, soft_standby_bit, formatBit};
	always #4 clk = ~clk;
	acr_host_model host (
		.chipSelect_n         (chipSelect_n),
		.writeStrobe_n        (writeStrobe_n),
		.serialClock          (serialClock),
		.transmit_frame_sync_n(transmit_frame_sync_n),
		.serialDataIn         (serialDataIn),
		.parallelData         (parallelData),
		.clk                  (clk)
	);
	acr_control_reg #(
		.SETTLE_COUNT(4)
	) dut (
		.clk                  (clk),
		.nrst                 (nrst),
		.parallelSelect       (parallelSelect),
		.chipSelect_n         (chipSelect_n),
		.writeStrobe_n        (writeStrobe_n),
		.parallelData         (parallelData),
		.serialClock          (serialClock),
		.transmit_frame_sync_n(transmit_frame_sync_n),
		.serialDataIn         (serialDataIn),
		.channelSel           (channelSel),
		.soft_convert_bit     (soft_convert_bit),
		.soft_standby_bit     (soft_standby_bit),
		.formatBit            (formatBit),
		.convertStart         (convertStart)
	);
	// Pulse count, sampled mid-cycle where the pulse is settled; ceiling far above the 426 cycles the run needs
	always @(negedge clk) begin
		nConv <= nConv + int'(convertStart === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			nErrors++;
			print_verdict();
		end
	end
	task automatic check(input logic [7:0] seen, exp);
		nCompared++;
		if (seen !== exp) begin
			nErrors++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		if (nErrors == 0 && nCompared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Only the first step runs in parallel mode, so step two must be ignored
	initial begin
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		check({regBits, 2'h0}, 8'h00);
		repeat (2) @(negedge clk);
		for (int i = 0; i < 7; i++) begin
			parallelSelect = (i == 0);
			if (nb[i] == 0) host.parWrite(dat[i][5:0]);
			else host.serWrite(dat[i], nb[i]);
			check({regBits, nConv[1:0]}, expv[i]);
		end
		print_verdict();
	end
endmodule
